// >>> abx_alu.sv
`timescale 1ns/1ps
module abx_alu (
    input  abx_pkg::abx_op_t op,
    input  wire logic [7:0]  acc,
    input  wire logic [7:0]  file_byte,
    input  wire logic [7:0]  literal,
    input  wire logic [2:0]  bit_idx,
    input  wire logic        dest,
    input  wire logic [3:0]  flags_in,
    output logic      [7:0]  result,
    output logic      [3:0]  flags_out,
    output logic      [3:0]  flag_mask,
    output logic             wr_acc,
    output logic             wr_file,
    output logic             skip
);
    import abx_pkg::*;

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        return 8'h01 << idx;
    endfunction : bit_mask

    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] and_f;
    logic       sel_bit;

    assign sum9    = {1'b0, acc} + {1'b0, file_byte} + {8'h00, flags_in[ST_C_BIT]};
    assign sum5    = {1'b0, acc[3:0]} + {1'b0, file_byte[3:0]} + {4'h0, flags_in[ST_C_BIT]};
    assign and_f   = acc & file_byte;
    assign sel_bit = file_byte[bit_idx];

    always_comb begin
        result    = file_byte;
        flags_out = flags_in;
        flag_mask = 4'h0;
        wr_acc    = 1'b0;
        wr_file   = 1'b0;
        skip      = 1'b0;
        unique case (op)
            add_with_carry_op: begin
                result                = sum9[7:0];
                flags_out[ST_C_BIT]   = sum9[8];
                flags_out[ST_DC_BIT]  = sum5[4];
                flags_out[ST_Z_BIT]   = (sum9[7:0] == 8'h00);
                flags_out[ST_OV_BIT]  = (acc[7] == file_byte[7]) && (sum9[7] != acc[7]);
                flag_mask             = 4'hf;
                wr_acc                = ~dest;
                wr_file               = dest;
            end
            and_literal_op: begin
                result               = acc & literal;
                flags_out[ST_Z_BIT]  = ((acc & literal) == 8'h00);
                flag_mask[ST_Z_BIT]  = 1'b1;
                wr_acc               = 1'b1;
            end
            and_register_op: begin
                result               = and_f;
                flags_out[ST_Z_BIT]  = (and_f == 8'h00);
                flag_mask[ST_Z_BIT]  = 1'b1;
                wr_acc               = ~dest;
                wr_file              = dest;
            end
            bit_clear_op: begin
                result  = file_byte & ~bit_mask(bit_idx);
                wr_file = 1'b1;
            end
            bit_set_op: begin
                result  = file_byte | bit_mask(bit_idx);
                wr_file = 1'b1;
            end
            test_skip_if_zero_op: skip = ~sel_bit;
            test_skip_if_one_op:  skip = sel_bit;
            op_none: ;
        endcase
    end

endmodule : abx_alu

// >>> abx_exec.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module abx_exec #(
    parameter int APB_ADDR_W = 8
) (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [APB_ADDR_W-1:0] PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic [15:0]           IR_DATA,
    input  wire logic                  IR_VALID,
    output logic                       IR_TAKE,
    output logic      [7:0]            DM_ADDR,
    input  wire logic [7:0]            DM_RDATA,
    output logic      [7:0]            DM_WDATA,
    output logic                       DM_WE
);
    import abx_pkg::*;

    if (APB_ADDR_W < 8) begin : g_addr_check
        $error("APB_ADDR_W too small for the register map");
    end

    //////////////////////////////////////////////////////////////////////////
    // state
    abx_phase_t  phase_reg;
    abx_phase_t  phase_next;
    abx_op_t     op_reg;
    logic [15:0] exec_ir_reg;
    logic [15:0] exec_ir_next;
    logic [7:0]  operand_reg;
    logic [7:0]  result_reg;
    logic [3:0]  flag_val_reg;
    logic [3:0]  flag_mask_reg;
    logic        wr_acc_reg;
    logic        skip_take_reg;
    logic        skip_reg;
    logic        run_reg;
    logic        step_reg;
    logic [7:0]  acc_reg;
    logic [7:0]  acc_next;
    logic [3:0]  status_reg;
    logic [3:0]  status_next;
    logic [31:0] count_reg;
    logic [7:0]  dm_addr_reg;
    logic [7:0]  dm_wdata_reg;
    logic        dm_we_reg;
    logic        ir_take_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;

    //////////////////////////////////////////////////////////////////////////
    // alu
    logic [7:0] alu_result;
    logic [3:0] alu_flags;
    logic [3:0] alu_mask;
    logic       alu_wr_acc;
    logic       alu_wr_file;
    logic       alu_skip;

    abx_alu u_alu (
        .op        (op_reg),
        .acc       (acc_reg),
        .file_byte (operand_reg),
        .literal   (exec_ir_reg[7:0]),
        .bit_idx   (exec_ir_reg[10:8]),
        .dest      (exec_ir_reg[8]),
        .flags_in  (status_reg),
        .result    (alu_result),
        .flags_out (alu_flags),
        .flag_mask (alu_mask),
        .wr_acc    (alu_wr_acc),
        .wr_file   (alu_wr_file),
        .skip      (alu_skip)
    );

    //////////////////////////////////////////////////////////////////////////
    // apb decode
    wire apb_setup  = PSEL & PENABLE & ~pready_reg;
    wire apb_done   = PSEL & PENABLE & pready_reg;
    wire apb_wr     = apb_done & PWRITE;
    wire [7:0] addr = PADDR[7:0];
    wire hit_ctrl   = (addr == CTRL_OFF);
    wire hit_acc    = (addr == ACC_OFF);
    wire hit_status = (addr == STATUS_OFF);
    wire hit_state  = (addr == STATE_OFF);
    wire hit_count  = (addr == COUNT_OFF);
    wire hit_any    = hit_ctrl | hit_acc | hit_status | hit_state | hit_count;
    wire hi_zero    = (APB_ADDR_W <= 8) ? 1'b1 : ((PADDR >> 8) == '0);
    wire mapped     = hit_any & hi_zero;
    wire wr_ctrl    = apb_wr & mapped & hit_ctrl;
    wire wr_acc_sw  = apb_wr & mapped & hit_acc;
    wire wr_stat_sw = apb_wr & mapped & hit_status;

    //////////////////////////////////////////////////////////////////////////
    // phase sequencing
    // a cycle once started always finishes, so stopping never leaves a
    // half-written file byte behind
    wire busy     = phase_reg != PH_DECODE;
    wire active   = run_reg | step_reg | busy;
    wire in_dec   = active & (phase_reg == PH_DECODE);
    wire in_read  = phase_reg == PH_READ;
    wire in_proc  = phase_reg == PH_PROCESS;
    wire in_write = phase_reg == PH_WRITE;

    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_DECODE:  if (active) phase_next = PH_READ;
            PH_READ:    phase_next = PH_PROCESS;
            PH_PROCESS: phase_next = PH_WRITE;
            PH_WRITE:   phase_next = PH_DECODE;
        endcase
    end

    // fetch slot at the end of every cycle; a taken skip throws it away
    wire fetch_ok = ir_take_reg & IR_VALID;
    assign exec_ir_next = skip_take_reg ? NOP_WORD :
                          fetch_ok      ? IR_DATA  :
                                          NOP_WORD;

    //////////////////////////////////////////////////////////////////////////
    // accumulator and flags: the instruction's write beats a software write
    // landing on the same edge
    wire hw_acc_wr = in_write & wr_acc_reg;
    assign acc_next = hw_acc_wr ? result_reg :
                      wr_acc_sw ? PWDATA[7:0] :
                                  acc_reg;

    wire [3:0] sw_status = wr_stat_sw ? PWDATA[3:0] : status_reg;
    wire [3:0] hw_mask   = in_write ? flag_mask_reg : 4'h0;
    assign status_next = (sw_status & ~hw_mask) | (flag_val_reg & hw_mask);

    //////////////////////////////////////////////////////////////////////////
    // read mux
    wire [31:0] state_word = {exec_ir_reg, 12'h000, busy, skip_reg, phase_reg};
    wire [31:0] rd_mux = hit_ctrl   ? {30'h0, step_reg, run_reg} :
                         hit_acc    ? {24'h0, acc_reg} :
                         hit_status ? {28'h0, status_reg} :
                         hit_state  ? state_word :
                         hit_count  ? count_reg :
                                      32'h0;

    //////////////////////////////////////////////////////////////////////////
    // sequencer flops
    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_reg <= PH_DECODE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            op_reg      <= op_none;
            dm_addr_reg <= 8'h00;
        end else if (in_dec) begin
            op_reg      <= abx_decode(exec_ir_reg);
            dm_addr_reg <= exec_ir_reg[7:0];
        end
    end

    // file byte sampled at the end of the read phase
    always_ff @(posedge CLK) begin
        if (RST) begin
            operand_reg <= 8'h00;
        end else if (in_read) begin
            operand_reg <= DM_RDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            result_reg    <= 8'h00;
            flag_val_reg  <= 4'h0;
            flag_mask_reg <= 4'h0;
            wr_acc_reg    <= 1'b0;
            skip_take_reg <= 1'b0;
        end else if (in_proc) begin
            result_reg    <= alu_result;
            flag_val_reg  <= alu_flags;
            flag_mask_reg <= alu_mask;
            wr_acc_reg    <= alu_wr_acc;
            skip_take_reg <= alu_skip;
        end
    end

    // write strobe and fetch strobe stand through the write phase only
    always_ff @(posedge CLK) begin
        if (RST) begin
            dm_wdata_reg <= 8'h00;
            dm_we_reg    <= 1'b0;
            ir_take_reg  <= 1'b0;
        end else begin
            if (in_proc) begin
                dm_wdata_reg <= alu_result;
            end
            dm_we_reg   <= in_proc & alu_wr_file;
            ir_take_reg <= in_proc;
        end
    end

    // one word per cycle; the next word is in place for the next decode
    always_ff @(posedge CLK) begin
        if (RST) begin
            exec_ir_reg <= NOP_WORD;
            skip_reg    <= 1'b0;
            count_reg   <= 32'h0;
        end else if (in_write) begin
            exec_ir_reg <= exec_ir_next;
            skip_reg    <= skip_take_reg;
            count_reg   <= count_reg + 32'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // software visible state
    always_ff @(posedge CLK) begin
        if (RST) begin
            acc_reg    <= ACC_RST;
            status_reg <= STATUS_RST;
        end else begin
            acc_reg    <= acc_next;
            status_reg <= status_next;
        end
    end

    // step is self clearing: it runs exactly one instruction cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            run_reg  <= 1'b0;
            step_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                run_reg <= PWDATA[CTRL_RUN_BIT];
            end
            if (wr_ctrl & PWDATA[CTRL_STEP_BIT]) begin
                step_reg <= 1'b1;
            end else if (in_write) begin
                step_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer registered
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup & ~mapped;
            if (apb_setup) begin
                prdata_reg <= (mapped & ~PWRITE) ? rd_mux : 32'h0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs
    assign PRDATA   = prdata_reg;
    assign PREADY   = pready_reg;
    assign PSLVERR  = pslverr_reg;
    assign IR_TAKE  = ir_take_reg;
    assign DM_ADDR  = dm_addr_reg;
    assign DM_WDATA = dm_wdata_reg;
    assign DM_WE    = dm_we_reg;

endmodule : abx_exec

// >>> abx_exec_bench.sv
`timescale 1ns/1ps
module abx_exec_bench;
    import abx_pkg::*;

    // accumulator, file byte, carry in, destination
    localparam logic [17:0] ADD_CASES [4] = '{{8'h4d, 8'h02, 2'b10}, {8'h7f, 8'h00, 2'b11},
                                              {8'hff, 8'h00, 2'b10}, {8'h80, 8'h80, 2'b01}};
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] ir_data;
    logic        ir_valid, ir_take, dm_we;
    logic [7:0]  dm_addr, dm_rdata, dm_wdata;
    logic [7:0]  dmem [256];
    int          num_errors, check_count, n_steps;

    abx_exec i_dut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IR_DATA(ir_data), .IR_VALID(ir_valid), .IR_TAKE(ir_take),
        .DM_ADDR(dm_addr), .DM_RDATA(dm_rdata), .DM_WDATA(dm_wdata), .DM_WE(dm_we)
    );

    assign dm_rdata = dmem[dm_addr];
    always @(posedge clk) begin
        if (dm_we === 1'b1) begin
            dmem[dm_addr] <= dm_wdata;
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic ran_out;
        num_errors++;
        $display("FAIL %0t wait ran out", $time);
        tally_and_finish();
    endtask : ran_out

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) ran_out();
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, wd, r, e);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, want);
    endtask : rdc

    // one instruction cycle: runs the word fetched before, fetches w
    task automatic step(input logic [15:0] w, input logic v);
        logic [31:0] r;
        logic        e;
        int          n;
        ir_data  <= w;
        ir_valid <= v;
        wr(CTRL_OFF, 32'h1 << CTRL_STEP_BIT);
        n = 0;
        do begin
            apb(1'b0, CTRL_OFF, 32'h0, r, e);
            n++;
        end while (r[CTRL_STEP_BIT] !== 1'b0 && n < 20);
        if (r[CTRL_STEP_BIT] !== 1'b0) ran_out();
        n_steps++;
    endtask : step

    task automatic exec1(input logic [15:0] w);
        step(w, 1'b1);
        step(NOP_WORD, 1'b1);
    endtask : exec1

    task automatic wait_take(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ir_take !== 1'b1 && n < 50);
        if (ir_take !== 1'b1) ran_out();
    endtask : wait_take

    // returns {overflow, zero, half carry, carry, sum}
    function automatic logic [11:0] addc(input logic [7:0] a, input logic [7:0] f,
                                         input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, f} + {8'h0, c};
        h = {1'b0, a[3:0]} + {1'b0, f[3:0]} + {4'h0, c};
        return {a[7] == f[7] && s[7] != a[7], s[7:0] == 8'h0, h[4], s[8], s[7:0]};
    endfunction : addc

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0]  a, f, fa;
        logic        c, d, skip, e;
        logic [11:0] res;
        logic [15:0] want_ir;
        logic [31:0] r;
        int          n;
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {ir_data, ir_valid} = {NOP_WORD, 1'b1};
        {num_errors, check_count, n_steps} = {32'h0, 32'h0, 32'h0};
        // known contents so the core never reads an unknown byte
        for (int i = 0; i < 256; i++) dmem[i] = 8'(i) ^ 8'ha5;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(ACC_OFF, 32'h0);
        apb(1'b0, 8'h14, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        wr(STATE_OFF, 32'hffff_ffff);
        rdc(STATE_OFF, 32'h0);
        for (int i = 0; i < 4; i++) begin
            {a, f, c, d} = ADD_CASES[i];
            fa = {i[1:0], 6'h3f};
            res = addc(a, f, c);
            wr(ACC_OFF, {24'h0, a});
            wr(STATUS_OFF, {31'h0, c});
            dmem[fa] = f;
            exec1({ADDC_HI7, d, fa});
            rdc(ACC_OFF, {24'h0, d ? a : res[7:0]});
            rdc(STATUS_OFF, {28'h0, res[11:8]});
            check({24'h0, dmem[fa]}, {24'h0, d ? res[7:0] : f});
        end
        wr(STATUS_OFF, 32'hb);
        wr(ACC_OFF, 32'ha3);
        exec1({ANDL_HI8, 8'h5c});
        rdc(ACC_OFF, 32'h0);
        rdc(STATUS_OFF, 32'hf);
        wr(ACC_OFF, 32'ha3);
        exec1({ANDL_HI8, 8'h5f});
        rdc(ACC_OFF, 32'h3);
        rdc(STATUS_OFF, 32'hb);
        wr(STATUS_OFF, 32'h9);
        wr(ACC_OFF, 32'h17);
        dmem[0] = 8'hc2;
        exec1({ANDF_HI7, 1'b1, 8'h00});
        check({24'h0, dmem[0]}, 32'h2);
        rdc(ACC_OFF, 32'h17);
        dmem[0] = 8'he8;
        exec1({ANDF_HI7, 1'b0, 8'h00});
        check({24'h0, dmem[0]}, 32'he8);
        rdc(ACC_OFF, 32'h0);
        rdc(STATUS_OFF, 32'hd);
        wr(STATUS_OFF, 32'h6);
        for (int k = 0; k < 8; k++) begin
            dmem[8'hff] = 8'h5a;
            exec1({BSET_HI5, 3'(k), 8'hff});
            check({24'h0, dmem[8'hff]}, {24'h0, 8'h5a | (8'h01 << k)});
            exec1({BCLR_HI5, 3'(k), 8'hff});
            check({24'h0, dmem[8'hff]}, {24'h0, 8'h5a & ~(8'h01 << k)});
        end
        rdc(STATUS_OFF, 32'h6);
        dmem[8'h10] = 8'h02;
        for (int j = 0; j < 4; j++) begin
            skip = j[1] ~^ j[0];
            wr(ACC_OFF, 32'hff);
            wr(STATUS_OFF, 32'h1);
            step({j[1] ? TSTO_HI5 : TSTZ_HI5, 2'b00, j[0], 8'h10}, 1'b1);
            step({ANDL_HI8, 8'h00}, 1'b1);
            // skip flag and held word describe the cycle about to run
            apb(1'b0, STATE_OFF, 32'h0, r, e);
            check({31'h0, r[STATE_SKIP_BIT]}, {31'h0, skip});
            want_ir = skip ? NOP_WORD : {ANDL_HI8, 8'h00};
            check({16'h0, r[STATE_IR_LSB +: 16]}, {16'h0, want_ir});
            step(NOP_WORD, 1'b1);
            rdc(ACC_OFF, skip ? 32'hff : 32'h0);
            rdc(STATUS_OFF, skip ? 32'h1 : 32'h5);
            apb(1'b0, STATE_OFF, 32'h0, r, e);
            check({31'h0, r[STATE_SKIP_BIT]}, 32'h0);
        end
        // no word on offer: the core must run a no-operation
        wr(ACC_OFF, 32'hff);
        step({ANDL_HI8, 8'h00}, 1'b0);
        step(NOP_WORD, 1'b1);
        rdc(ACC_OFF, 32'hff);
        rdc(COUNT_OFF, 32'(n_steps));
        // free run on a test that always skips: test and no-op cycles alternate
        ir_data <= {TSTO_HI5, 3'h1, 8'h10};
        wr(CTRL_OFF, 32'h1 << CTRL_RUN_BIT);
        wait_take(n);
        for (int m = 0; m < 3; m++) begin
            wait_take(n);
            check(32'(n), 32'h4);
        end
        tally_and_finish();
    end
endmodule : abx_exec_bench

// >>> abx_exec_sva.sv
`timescale 1ns/1ps
module abx_exec_sva
    import abx_pkg::*;
#(
    parameter int APB_ADDR_W = 8
) (
    input wire logic                  CLK,
    input wire logic                  RST,
    input wire logic                  PSEL,
    input wire logic                  PENABLE,
    input wire logic                  PWRITE,
    input wire logic [APB_ADDR_W-1:0] PADDR,
    input wire logic [31:0]           PWDATA,
    input wire logic [31:0]           PRDATA,
    input wire logic                  PREADY,
    input wire logic                  PSLVERR,
    input wire logic [15:0]           IR_DATA,
    input wire logic                  IR_VALID,
    input wire logic                  IR_TAKE,
    input wire logic [7:0]            DM_ADDR,
    input wire logic [7:0]            DM_RDATA,
    input wire logic [7:0]            DM_WDATA,
    input wire logic                  DM_WE
);
    logic [15:0] cur_reg, cur_next;
    logic        skip_reg, skip_next;

    // a discarded word still lands in cur_reg, so skip_reg marks its cycle
    assign cur_next  = IR_TAKE ? (IR_VALID ? IR_DATA : NOP_WORD) : cur_reg;
    assign skip_next = IR_TAKE ? (!skip_reg && cur_reg[15:12] == 4'h9
                       && DM_RDATA[cur_reg[10:8]] == !cur_reg[11]) : skip_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            cur_reg  <= NOP_WORD;
            skip_reg <= 1'b0;
        end else begin
            cur_reg  <= cur_next;
            skip_reg <= skip_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_take_spacing: assert property (IR_TAKE |=> !IR_TAKE [*3])
        else $error("fetch strobes too close");
    a_write_phase: assert property (DM_WE |-> IR_TAKE)
        else $error("file write outside write phase");
    a_addr_field: assert property (
        DM_WE |-> DM_ADDR == cur_reg[7:0] && $stable(DM_ADDR))
        else $error("file address not from word");
    a_set_byte: assert property (
        DM_WE && cur_reg[15:11] == BSET_HI5 |->
        DM_WDATA == ($past(DM_RDATA, 2) | (8'h01 << cur_reg[10:8])))
        else $error("bit set byte wrong");
    a_clear_byte: assert property (
        DM_WE && cur_reg[15:11] == BCLR_HI5 |->
        DM_WDATA == ($past(DM_RDATA, 2) & ~(8'h01 << cur_reg[10:8])))
        else $error("bit clear byte wrong");
    a_skip_quiet: assert property (IR_TAKE && skip_reg |-> !DM_WE)
        else $error("skipped word wrote memory");
    a_addc_dest: assert property (
        IR_TAKE && !skip_reg && cur_reg[15:9] == ADDC_HI7 |-> DM_WE == cur_reg[8])
        else $error("add with carry destination wrong");
    a_andf_dest: assert property (
        IR_TAKE && !skip_reg && cur_reg[15:9] == ANDF_HI7 |-> DM_WE == cur_reg[8])
        else $error("and register destination wrong");
    a_quiet_ops: assert property (
        IR_TAKE && (cur_reg[15:12] == 4'h9 || cur_reg[15:8] == ANDL_HI8) |-> !DM_WE)
        else $error("file written by literal or test");

    c_bit_set: cover property (DM_WE && cur_reg[15:11] == BSET_HI5);
    c_skip: cover property (IR_TAKE && skip_reg);
    c_slv_err: cover property (PSLVERR);
endmodule : abx_exec_sva

bind abx_exec abx_exec_sva #(.APB_ADDR_W(APB_ADDR_W)) i_sva (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IR_DATA(IR_DATA), .IR_VALID(IR_VALID), .IR_TAKE(IR_TAKE),
    .DM_ADDR(DM_ADDR), .DM_RDATA(DM_RDATA), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE)
);

// >>> abx_pkg.sv
package abx_pkg;

    //////////////////////////////////////////////////////////////////////////
    // register map, byte addresses of aligned 32-bit words
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] ACC_OFF    = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam logic [7:0] STATE_OFF  = 8'h0c;
    localparam logic [7:0] COUNT_OFF  = 8'h10;

    // control fields
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_STEP_BIT = 1;

    // status fields
    localparam int ST_C_BIT  = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_Z_BIT  = 2;
    localparam int ST_OV_BIT = 3;

    // state fields
    localparam int STATE_PH_LSB   = 0;
    localparam int STATE_SKIP_BIT = 2;
    localparam int STATE_BUSY_BIT = 3;
    localparam int STATE_IR_LSB   = 16;

    // reset values
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [3:0]  STATUS_RST = 4'h0;
    localparam logic [15:0] NOP_WORD   = 16'h0000;

    //////////////////////////////////////////////////////////////////////////
    // opcode patterns on the upper bits of the instruction word
    localparam logic [6:0] ADDC_HI7 = 7'h08;
    localparam logic [6:0] ANDF_HI7 = 7'h05;
    localparam logic [7:0] ANDL_HI8 = 8'hb5;
    localparam logic [4:0] BSET_HI5 = 5'h10;
    localparam logic [4:0] BCLR_HI5 = 5'h11;
    localparam logic [4:0] TSTO_HI5 = 5'h12;
    localparam logic [4:0] TSTZ_HI5 = 5'h13;

    typedef enum logic [2:0] {
        op_none,
        add_with_carry_op,
        and_literal_op,
        and_register_op,
        bit_clear_op,
        bit_set_op,
        test_skip_if_zero_op,
        test_skip_if_one_op
    } abx_op_t;

    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } abx_phase_t;

    // anything outside the group executes as a no-operation
    function automatic abx_op_t abx_decode(input logic [15:0] ir);
        abx_op_t op;
        op = op_none;
        if (ir[15:9] == ADDC_HI7)
            op = add_with_carry_op;
        else if (ir[15:8] == ANDL_HI8)
            op = and_literal_op;
        else if (ir[15:9] == ANDF_HI7)
            op = and_register_op;
        else if (ir[15:11] == BCLR_HI5)
            op = bit_clear_op;
        else if (ir[15:11] == BSET_HI5)
            op = bit_set_op;
        else if (ir[15:11] == TSTZ_HI5)
            op = test_skip_if_zero_op;
        else if (ir[15:11] == TSTO_HI5)
            op = test_skip_if_one_op;
        return op;
    endfunction : abx_decode

endpackage : abx_pkg
